// file: inc/amp_map.vh
/*
 * Constants for one asynchronous port of the serial port group:
 * command bit positions, input control word layout,
 * control block word offsets, character classes and FIFO shape.
 * Bit positions count from the least significant bit (0) upward.
 * Assumes it is included by bare name from the receiver and port design files.
 */
`ifndef AMP_MAP_VH
`define AMP_MAP_VH

// ==========================================
// Command register (low byte of an output_to_port_op write; clock enable from bit 15)
`define AMP_CMD_RXIE 7
`define AMP_CMD_TXC_HI 6
`define AMP_CMD_TXC_LO 5
`define AMP_CMD_FMT_HI 4
`define AMP_CMD_FMT_LO 2
`define AMP_CMD_RTC 15
`define AMP_CMD_RESET 8'h09
`define AMP_DIV_MRST 2'b11
`define AMP_DIV_16 2'b01
`define AMP_TXC_IE 2'b01
`define AMP_TXC_RTS 2'b10
`define AMP_TXC_BRK 2'b11

// ==========================================
// Input control word
`define AMP_ICW_IOC 15
`define AMP_ICW_MODE_HI 14
`define AMP_ICW_MODE_LO 13
`define AMP_ICW_SPEN 12
`define AMP_IN_AUTO 2'b10
`define AMP_IN_ECHO 2'b11

// ==========================================
// Control block word offsets
`define AMP_W_ICW 16'h0000
`define AMP_W_IBP 16'h0004
`define AMP_W_LIB 16'h0006

// ==========================================
// Special characters and marking
`define AMP_SPC_LOW 8'h20
`define AMP_SPC_HI_LO 8'h7c
`define AMP_SPC_HI_HI 8'h7f
`define AMP_CHR_MARK 8'h80

// ==========================================
// Oversampling and FIFO
`define AMP_OVS_MID 4'h7
`define AMP_OVS_LAST 4'hf
`define AMP_FIFO_W 10
`define AMP_FIFO_D 32
`define AMP_FIFO_AW 5
`define AMP_PIN_RST 3'b001

`endif

// file: design/amp_fifo.v
/*
 * Receive FIFO between the character receiver and the holding register.
 * Assumes a single clock; flush empties it in one cycle.
 */
module amp_fifo #(
	parameter W = 10,
	parameter D = 32,
	parameter AW = 5
)(
	// Clock and reset
	input wire mclk,
	input wire nrst,
	input wire flush,
	// Filling side
	input wire in_valid,
	input wire [W-1:0] in_data,
	output wire in_ready,
	// Draining side
	output wire out_valid,
	output wire [W-1:0] out_data,
	input wire out_ready
);
	localparam [AW:0] FULL = D[AW:0];

	reg [W-1:0] mem [0:D-1]; // Flip-flop storage
	reg [AW-1:0] wp; // Write index
	reg [AW-1:0] rp; // Read index
	reg [AW:0] count; // Words held

	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	assign in_ready = (count != FULL);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rp];

	// ==========================================
	// Storage
	always @(posedge mclk)
	begin
		if (push)
			mem[wp] <= in_data;
	end

	// ==========================================
	// Pointers and occupancy
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else if (flush)
		begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wp <= wp + 1'b1;
			if (pop)
				rp <= rp + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end
endmodule

// file: design/amp_rx.v
/*
 * Character receiver: start detect and mid-bit sampling on a
 * sixteen-times tick. Assumes rxd is already synchronised.
 */
`include "amp_map.vh"
module amp_rx (
	// Clock and reset
	input wire mclk,
	input wire nrst,
	// Control
	input wire run,
	input wire tick,
	input wire rxd,
	input wire len8,
	input wire pen,
	input wire odd,
	// Character out
	output reg done,
	output reg [7:0] data,
	output reg pe,
	output reg fe
);
	localparam [1:0] S_IDLE = 2'd0;
	localparam [1:0] S_START = 2'd1;
	localparam [1:0] S_BITS = 2'd2;
	localparam [1:0] S_STOP = 2'd3;

	reg [1:0] st; // Receiver state
	reg [3:0] ph; // Tick phase within a bit
	reg [3:0] cnt; // Bits taken
	reg [8:0] sh; // Data and parity, shifted in from the top

	wire [3:0] nbits = 4'd7 + {3'b000, len8} + {3'b000, pen};
	wire [8:0] al = sh >> (4'd9 - nbits);
	wire [7:0] dat = len8 ? al[7:0] : {1'b0, al[6:0]};
	wire pbit = len8 ? al[8] : al[7];

	// ==========================================
	// Frame sampler
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			st <= S_IDLE;
			ph <= 4'h0;
			cnt <= 4'h0;
			sh <= 9'h000;
			done <= 1'b0;
			data <= 8'h00;
			pe <= 1'b0;
			fe <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (!run)
				st <= S_IDLE;
			else if (tick)
			begin
				ph <= ph + 4'h1;
				case (st)
				S_IDLE:
				begin
					ph <= 4'h0;
					if (!rxd)
						st <= S_START;
				end
				S_START:
					// Recheck the start bit at its middle to reject glitches
					if (ph == `AMP_OVS_MID) // R25
					begin
						ph <= 4'h0;
						cnt <= 4'h0;
						st <= rxd ? S_IDLE : S_BITS;
					end
				S_BITS:
					if (ph == `AMP_OVS_LAST) // R25
					begin
						sh <= {rxd, sh[8:1]};
						cnt <= cnt + 4'h1;
						if (cnt == nbits - 4'h1)
							st <= S_STOP;
					end
				default:
					if (ph == `AMP_OVS_LAST)
					begin
						// Only the first stop bit is checked
						done <= 1'b1;
						data <= dat;
						pe <= pen & (^dat ^ pbit ^ odd); // R06
						fe <= ~rxd; // R08
						st <= S_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// file: design/amp_port.v
/*
 * One asynchronous port of the serial port group: command and status
 * registers for programmed I/O byte mode, receiver, transmitter, and
 * the auto-mode engine that updates the port_control_block over DMA.
 * Assumes one clock, a sixteen-times bit tick from same-clock logic,
 * and a DMA slave that answers each request with one ack pulse.
 */
// Notes on behaviour
// R01: Software master-resets before changing the mode
// R02: Then writes mode bits with divide-by-16 code
// R03: Only divide-by-16 runs; master reset holds idle
// R04: Status read returns upper byte as zero
// R05: Interrupt status bit unused in byte mode; here it shows the enabled receive and transmit interrupt conditions
// R06: Parity flag only while enabled; none suppresses parity
// R07: Overrun shows after prior char read; read clears
// R08: Framing flag while the bad character is held
// R09: Clear-to-send mirrored and inhibits transmit-empty
// R10: Carrier loss sticky until status and data read
// R11: Transmit-empty once holding register moved to shifter
// R12: Receive-full on new character; cleared by read
// R13: Control block: words 0,4,6 input; 2,3 ignored
// R14: Software places control blocks contiguously, 40-octal spaced
// R15: Port format held only in command register
// R16: Input complete on full, errors, single, special, carrier
// R17: Special is below 40 or 174-177 octal
// R18: Input complete also sets pending and requests interrupt
// R19: Service program clears input complete within character
// R20: Later character overwrites stored low byte
// R21: Single mode stores each character and interrupts
// R22: Command selects receive and transmit interrupts, RTS, break
// R23: Command selects one of eight character formats
// R24: Auto input fills buffer up to last byte
// R25: Receiver samples bits at midpoint on sixteen-times tick
// R26: Input control word written back on each update; here only when input completes
`include "amp_map.vh"
module amp_port (
	// Clock and reset
	input wire mclk,
	input wire nrst,
	// Programmed I/O
	input wire pio_cmd_wr,
	input wire pio_dat_wr,
	input wire pio_stat_rd,
	input wire pio_dat_rd,
	input wire [15:0] pio_wdata,
	output reg [15:0] pio_rdata,
	output reg rtc_en,
	// Auto mode and interrupt
	input wire auto_en,
	input wire [15:0] cb_base,
	input wire pend_clr,
	output reg irq,
	// DMA
	output wire dma_req,
	output reg dma_we,
	output reg [15:0] dma_addr,
	output reg [15:0] dma_wdata,
	input wire dma_ack,
	input wire [15:0] dma_rdata,
	// Serial line
	input wire tick_x16,
	input wire rxd,
	input wire cts_n,
	input wire dcd_n,
	output reg txd,
	output reg rts
);
	localparam [2:0] E_IDLE = 3'd0;
	localparam [2:0] E_ICW = 3'd1;
	localparam [2:0] E_IBP = 3'd2;
	localparam [2:0] E_LIB = 3'd3;
	localparam [2:0] E_BUF = 3'd4;
	localparam [2:0] E_WBUF = 3'd5;
	localparam [2:0] E_WIBP = 3'd6;
	localparam [2:0] E_WICW = 3'd7;

	// ==========================================
	// Command decode
	reg [7:0] cmd; // Port format and control, the only copy of it
	wire mrst = (cmd[1:0] == `AMP_DIV_MRST);
	wire run = (cmd[1:0] == `AMP_DIV_16); // R03
	wire [2:0] fmt = cmd[`AMP_CMD_FMT_HI:`AMP_CMD_FMT_LO];
	wire len8 = fmt[2]; // R23
	wire pen = ~(fmt[2] & ~fmt[1]); // R23
	wire odd = fmt[0];
	wire stop2 = (~fmt[2] & ~fmt[1]) | (fmt == 3'b100);
	wire [1:0] txc = cmd[`AMP_CMD_TXC_HI:`AMP_CMD_TXC_LO];
	wire rxie = cmd[`AMP_CMD_RXIE];

	// Command register write; parameters never come from memory
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cmd <= `AMP_CMD_RESET;
			rtc_en <= 1'b0;
		end
		else if (pio_cmd_wr)
		begin
			cmd <= pio_wdata[7:0]; // R15
			rtc_en <= pio_wdata[`AMP_CMD_RTC];
		end
	end

	// ==========================================
	// Pin synchronisers: a change counts once stages two and three agree
	reg [2:0] p1; // First stage, read only by p2
	reg [2:0] p2;
	reg [2:0] p3;
	reg [2:0] pf; // Accepted levels: rxd, cts_n, dcd_n
	wire rxd_s = pf[0];
	wire cts_s = pf[1];
	wire dcd_s = pf[2];

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			p1 <= `AMP_PIN_RST;
			p2 <= `AMP_PIN_RST;
			p3 <= `AMP_PIN_RST;
			pf <= `AMP_PIN_RST;
		end
		else
		begin
			p1 <= {dcd_n, cts_n, rxd};
			p2 <= p1;
			p3 <= p2;
			pf <= (p2 & p3) | (pf & (p2 ^ p3));
		end
	end

	// ==========================================
	// Receiver, FIFO and holding register
	wire rx_done;
	wire [7:0] rx_data;
	wire rx_pe;
	wire rx_fe;
	wire f_in_ready;
	wire f_out_valid;
	wire [9:0] f_out_data;
	reg hold_full; // Character held in the receive-data register
	reg [7:0] hold_data;
	reg hold_pe;
	reg hold_fe;
	reg ovr; // Visible overrun flag
	reg ovr_pend; // Loss seen, not yet shown
	reg dcd_flag; // Sticky carrier loss
	reg dcd_seen; // Status was read while carrier loss showed
	reg [2:0] est;

	// Carrier loss disables the receiver
	amp_rx u_rx (
		.mclk(mclk),
		.nrst(nrst),
		.run(run & ~dcd_s),
		.tick(tick_x16),
		.rxd(rxd_s),
		.len8(len8),
		.pen(pen),
		.odd(odd),
		.done(rx_done),
		.data(rx_data),
		.pe(rx_pe),
		.fe(rx_fe)
	);

	// The receiver is never stalled; a character the full FIFO refuses is lost
	amp_fifo #(.W(`AMP_FIFO_W), .D(`AMP_FIFO_D), .AW(`AMP_FIFO_AW)) u_fifo (
		.mclk(mclk),
		.nrst(nrst),
		.flush(mrst),
		.in_valid(rx_done),
		.in_data({rx_fe, rx_pe, rx_data}),
		.in_ready(f_in_ready),
		.out_valid(f_out_valid),
		.out_data(f_out_data),
		.out_ready(~hold_full)
	);

	wire eng_take = (est == E_IDLE) & auto_en & run & hold_full;
	wire consume = pio_dat_rd | eng_take;
	wire lost = rx_done & ~f_in_ready;

	// Holding register and its error flags
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			hold_full <= 1'b0;
			hold_data <= 8'h00;
			hold_pe <= 1'b0;
			hold_fe <= 1'b0;
			ovr <= 1'b0;
			ovr_pend <= 1'b0;
		end
		else if (mrst)
		begin
			hold_full <= 1'b0; // R12
			ovr <= 1'b0; // R07
			ovr_pend <= 1'b0;
		end
		else
		begin
			if (consume)
			begin
				// The first character read after the loss exposes it
				hold_full <= 1'b0; // R12
				ovr <= ovr_pend; // R07
				ovr_pend <= 1'b0;
			end
			// Separate test: a read of an empty register must not drop a char popped now
			if (f_out_valid & ~hold_full)
			begin
				hold_full <= 1'b1; // R12
				hold_data <= f_out_data[7:0];
				hold_pe <= f_out_data[8];
				hold_fe <= f_out_data[9];
			end
			if (lost)
				ovr_pend <= 1'b1; // R07
		end
	end

	// Carrier loss: status read then data read clears; the set wins
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			dcd_flag <= 1'b0;
			dcd_seen <= 1'b0;
		end
		else if (mrst)
		begin
			dcd_flag <= 1'b0;
			dcd_seen <= 1'b0;
		end
		else
		begin
			if (pio_stat_rd & dcd_flag)
				dcd_seen <= 1'b1; // R10
			if (pio_dat_rd & dcd_seen)
			begin
				dcd_flag <= 1'b0; // R10
				dcd_seen <= 1'b0;
			end
			if (dcd_s)
				dcd_flag <= 1'b1; // R10
		end
	end

	// ==========================================
	// Transmitter
	reg tx_full; // Transmit-data register occupied
	reg [7:0] tx_hold;
	reg tx_busy;
	reg [11:0] tx_sr; // Remaining frame bits, LSB first
	reg [3:0] tx_left;
	reg [3:0] tx_ph;
	reg tx_line;
	reg e_echo; // Engine asks to echo e_chr
	reg [7:0] e_chr;
	wire [7:0] td = len8 ? tx_hold : {1'b0, tx_hold[6:0]};
	wire tpar = pen ? (^td ^ odd) : 1'b1; // R06
	wire [11:0] frame = len8 ? {2'b11, tpar, td, 1'b0} : {3'b111, tpar, td[6:0], 1'b0};
	wire [3:0] tx_nb = 4'd9 + {3'b000, len8} + {3'b000, pen} + {3'b000, stop2};
	wire tx_move = tx_full & ~tx_busy & ~cts_s & run; // R09

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_full <= 1'b0;
			tx_hold <= 8'h00;
			tx_busy <= 1'b0;
			tx_sr <= 12'hfff;
			tx_left <= 4'h0;
			tx_ph <= 4'h0;
			tx_line <= 1'b1;
			txd <= 1'b1;
			rts <= 1'b0;
		end
		else
		begin
			rts <= (txc == `AMP_TXC_RTS); // R22
			txd <= tx_line & ~(txc == `AMP_TXC_BRK); // R22
			if (mrst)
			begin
				tx_full <= 1'b0;
				tx_busy <= 1'b0;
				tx_line <= 1'b1;
			end
			else
			begin
				if (tx_move)
				begin
					// Register empties as the frame starts with its start bit
					tx_full <= 1'b0; // R11
					tx_busy <= 1'b1;
					tx_sr <= frame >> 1;
					tx_left <= tx_nb - 4'h1;
					tx_ph <= 4'h0;
					tx_line <= 1'b0;
				end
				else if (tx_busy & tick_x16)
				begin
					tx_ph <= tx_ph + 4'h1;
					if (tx_ph == `AMP_OVS_LAST)
					begin
						if (tx_left == 4'h0)
						begin
							tx_busy <= 1'b0;
							tx_line <= 1'b1;
						end
						else
						begin
							tx_line <= tx_sr[0];
							tx_sr <= {1'b1, tx_sr[11:1]};
							tx_left <= tx_left - 4'h1;
						end
					end
				end
				if (pio_dat_wr)
				begin
					tx_hold <= pio_wdata[7:0];
					tx_full <= 1'b1;
				end
				else if (e_echo & ~tx_full)
				begin
					tx_hold <= e_chr;
					tx_full <= 1'b1;
				end
			end
		end
	end

	// ==========================================
	// Status register and interrupt
	reg irq_pend; // Interrupt-pending for auto mode
	wire rx_holding_full = hold_full & ~dcd_flag; // R10
	wire tx_holding_empty = ~tx_full & ~cts_s; // R11
	wire irq_b = auto_en ? irq_pend : ((rxie & rx_holding_full) | ((txc == `AMP_TXC_IE) & tx_holding_empty)); // R05
	wire [7:0] stat = {irq_b, hold_pe & pen & hold_full, ovr, hold_fe & hold_full, cts_s, dcd_flag, tx_holding_empty, rx_holding_full};

	// Reads: upper byte always zero
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			pio_rdata <= 16'h0000;
			irq <= 1'b0;
		end
		else
		begin
			irq <= irq_b;
			if (pio_stat_rd)
				pio_rdata <= {8'h00, stat}; // R04
			else if (pio_dat_rd)
				pio_rdata <= {8'h00, hold_data}; // R04
		end
	end

	// ==========================================
	// Auto-mode engine
	reg [15:0] input_control_word; // Copy of the input control word
	reg [15:0] input_byte_pointer;
	reg [15:0] input_last_byte;
	reg [7:0] bufw; // Right half of the last buffer word written
	reg e_pe;
	reg e_fe;
	reg e_ovr;
	reg e_dcd;
	reg dcd_q;
	reg dcd_evt; // Carrier loss not yet reported in auto mode
	wire [1:0] mode = dma_rdata[`AMP_ICW_MODE_HI:`AMP_ICW_MODE_LO];
	wire is_spc = (e_chr < `AMP_SPC_LOW) | ((e_chr >= `AMP_SPC_HI_LO) & (e_chr <= `AMP_SPC_HI_HI)); // R17
	wire spc = dma_rdata[`AMP_ICW_SPEN] & is_spc; // R17
	wire err = e_pe | e_fe | e_ovr | e_dcd;
	wire auto_in = (mode == `AMP_IN_AUTO) | (mode == `AMP_IN_ECHO);
	wire [15:0] ibp_n = input_byte_pointer + 16'h0001;
	wire [7:0] chr_m = input_control_word[`AMP_ICW_SPEN] ? (e_chr | `AMP_CHR_MARK) : e_chr;
	wire [7:0] status4 = {1'b1, input_control_word[14:12], e_pe, e_ovr, e_fe, e_dcd};

	assign dma_req = (est != E_IDLE);

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			est <= E_IDLE;
			dma_we <= 1'b0;
			dma_addr <= 16'h0000;
			dma_wdata <= 16'h0000;
			input_control_word <= 16'h0000;
			input_byte_pointer <= 16'h0000;
			input_last_byte <= 16'h0000;
			bufw <= 8'h00;
			e_chr <= 8'h00;
			{e_pe, e_fe, e_ovr, e_dcd} <= 4'h0;
			e_echo <= 1'b0;
			dcd_q <= 1'b0;
			dcd_evt <= 1'b0;
			irq_pend <= 1'b0;
		end
		else
		begin
			dcd_q <= dcd_s;
			e_echo <= 1'b0;
			if (pend_clr)
				irq_pend <= 1'b0;
			case (est)
			E_IDLE:
				if (eng_take | (auto_en & dcd_evt))
				begin
					e_chr <= hold_data;
					e_pe <= eng_take & hold_pe & pen; // R06
					e_fe <= eng_take & hold_fe;
					e_ovr <= eng_take & ovr_pend;
					e_dcd <= ~eng_take; // R16
					if (~eng_take)
						dcd_evt <= 1'b0;
					dma_we <= 1'b0;
					dma_addr <= cb_base + `AMP_W_ICW; // R13
					est <= E_ICW;
				end
			E_ICW:
				if (dma_ack)
				begin
					input_control_word <= dma_rdata;
					if (auto_in & ~err & ~spc) // R24
					begin
						dma_addr <= cb_base + `AMP_W_IBP; // R13
						est <= E_IBP;
					end
					else
					begin
						// Single mode, error or special: overwrite the low byte
						dma_we <= 1'b1;
						dma_addr <= cb_base + `AMP_W_ICW;
						dma_wdata <= {1'b1, dma_rdata[14:12], e_pe, e_ovr, e_fe, e_dcd, e_chr}; // R16 R20 R21
						est <= E_WICW;
					end
				end
			E_IBP:
				if (dma_ack)
				begin
					input_byte_pointer <= dma_rdata;
					dma_addr <= cb_base + `AMP_W_LIB; // R13
					est <= E_LIB;
				end
			E_LIB:
				if (dma_ack)
				begin
					input_last_byte <= dma_rdata;
					input_byte_pointer <= ibp_n; // R24
					dma_addr <= {1'b0, ibp_n[15:1]};
					est <= E_BUF;
				end
			E_BUF:
				if (dma_ack)
				begin
					// Even byte pointer fills the left half of the word
					dma_wdata <= input_byte_pointer[0] ? {dma_rdata[15:8], chr_m} : {chr_m, dma_rdata[7:0]}; // R24
					bufw <= input_byte_pointer[0] ? chr_m : dma_rdata[7:0];
					dma_we <= 1'b1;
					e_echo <= (input_control_word[14:13] == `AMP_IN_ECHO);
					est <= E_WBUF;
				end
			E_WBUF:
				if (dma_ack)
				begin
					dma_addr <= cb_base + `AMP_W_IBP;
					dma_wdata <= input_byte_pointer;
					est <= E_WIBP;
				end
			E_WIBP:
				if (dma_ack)
				begin
					if (input_byte_pointer >= input_last_byte) // R24
					begin
						dma_addr <= cb_base + `AMP_W_ICW;
						dma_wdata <= {status4, bufw}; // R16
						est <= E_WICW;
					end
					else
					begin
						dma_we <= 1'b0;
						est <= E_IDLE;
					end
				end
			default:
				if (dma_ack)
				begin
					// The write-back completes the update and raises the request
					irq_pend <= 1'b1; // R18 R26
					dma_we <= 1'b0;
					est <= E_IDLE;
				end
			endcase
			if (dcd_s & ~dcd_q & auto_en)
				dcd_evt <= 1'b1; // R16
		end
	end
endmodule

// file: test/amp_port_asserts.sv
/*
 * Checker for amp_port: status, command and DMA relations at its ports.
 * Assumes it is bound to amp_port and that there is a single clock.
 */
module amp_port_chk (
	// Clock and reset
	input wire mclk,
	input wire nrst,
	// Programmed I/O
	input wire pio_cmd_wr,
	input wire pio_stat_rd,
	input wire [15:0] pio_wdata,
	input wire [15:0] pio_rdata,
	input wire rtc_en,
	// Auto mode
	input wire auto_en,
	input wire [15:0] cb_base,
	input wire irq,
	// DMA
	input wire dma_req,
	input wire dma_we,
	input wire [15:0] dma_addr,
	input wire [15:0] dma_wdata,
	input wire dma_ack,
	// Modem lines
	input wire cts_n,
	input wire dcd_n,
	input wire rts
);
	timeunit 1ns;
	timeprecision 1ns;
	// Last command fields, so the levels they drive can be judged
	reg [1:0] last_txc;
	reg last_rtc;
	// ==========
	// Helper logic
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			last_txc <= 2'b00;
			last_rtc <= 1'b0;
		end
		else if (pio_cmd_wr)
		begin
			last_txc <= pio_wdata[6:5];
			last_rtc <= pio_wdata[15];
		end
	end
	// ==========
	// Assertions
	default clocking dcb @(posedge mclk); endclocking
	default disable iff (!nrst);
	upper_byte_zero_a: assert property (pio_stat_rd |=> pio_rdata[15:8] == 8'h00)
		else $error("status upper byte not zero");
	// Six samples leave room for the three-flop pin synchroniser
	cts_inhibit_a: assert property (cts_n [*6] ##0 pio_stat_rd |=> pio_rdata[3] && !pio_rdata[1])
		else $error("clear-to-send not mirrored or not inhibiting");
	carrier_flag_a: assert property (dcd_n [*6] ##0 pio_stat_rd |=> pio_rdata[2] && !pio_rdata[0])
		else $error("carrier loss not shown or rx full not hidden");
	rts_level_a: assert property (!pio_cmd_wr [*3] |-> rts == (last_txc == 2'b10))
		else $error("rts level differs from command");
	rtc_level_a: assert property (!pio_cmd_wr [*3] |-> rtc_en == last_rtc)
		else $error("clock enable differs from command");
	irq_after_icw_a: assert property (auto_en && dma_ack && dma_we && dma_addr == cb_base && dma_wdata[15]
		|-> ##2 irq)
		else $error("no interrupt after completion write");
	dma_hold_a: assert property (dma_req && !dma_ack
		|=> dma_req && $stable(dma_addr) && $stable(dma_we) && $stable(dma_wdata))
		else $error("dma request changed before ack");
	icw_first_a: assert property ($rose(dma_req) |-> dma_addr == cb_base && !dma_we)
		else $error("engine did not start by reading word 0");
	block_write_a: assert property (dma_req && dma_we && (dma_addr - cb_base) < 16'd8
		|-> dma_addr == cb_base || dma_addr == cb_base + 16'd4)
		else $error("write to an unused control block word");
	// Main scenarios reached
	cover property (pio_stat_rd && cts_n);
	cover property (dma_ack && dma_we);
	cover property ($rose(irq));
endmodule

bind amp_port amp_port_chk amp_port_chk_i (.mclk, .nrst, .pio_cmd_wr, .pio_stat_rd, .pio_wdata, .pio_rdata,
	.rtc_en, .auto_en, .cb_base, .irq, .dma_req, .dma_we, .dma_addr, .dma_wdata, .dma_ack, .cts_n, .dcd_n, .rts);

// file: test/amp_host_mem.sv
/*
 * Host memory model: answers each DMA request of the port with one ack.
 * Assumes the port's clock; the wait before an ack is set by the bench.
 */
module amp_host_mem (
	// Clock
	input wire mclk,
	// DMA slave side
	input wire dma_req,
	input wire dma_we,
	input wire [15:0] dma_addr,
	input wire [15:0] dma_wdata,
	output logic dma_ack,
	output logic [15:0] dma_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Word store, answer wait and wait counter
	logic [15:0] mem [0:1023];
	int dly = 0;
	int cnt = 0;
	initial dma_ack = 1'b0;
	initial dma_rdata = 16'h0000;
	// ==========
	// Request handling
	always @(posedge mclk)
	begin
		if (dma_ack)
		begin
			// Writes land on the edge that takes the ack
			if (dma_we)
				mem[dma_addr[9:0]] <= dma_wdata;
			dma_ack <= 1'b0;
			// Read data is not held past its ack
			dma_rdata <= ~dma_rdata;
			cnt <= 0;
		end
		else if (dma_req && cnt >= dly)
		begin
			dma_ack <= 1'b1;
			dma_rdata <= mem[dma_addr[9:0]];
		end
		else if (dma_req)
			cnt <= cnt + 1;
	end
endmodule

// file: test/amp_port_tb.sv
/*
 * Bench for amp_port: byte mode through programmed I/O, a serial line
 * driven from here, and auto mode against the host memory model.
 * Assumes a 20 MHz clock and a x16 tick every fourth cycle.
 */
module amp_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Design inputs
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic pio_cmd_wr = 1'b0;
	logic pio_dat_wr = 1'b0;
	logic pio_stat_rd = 1'b0;
	logic pio_dat_rd = 1'b0;
	logic [15:0] pio_wdata = 16'h0000;
	logic auto_en = 1'b0;
	logic [15:0] cb_base = 16'h0100;
	logic pend_clr = 1'b0;
	logic tick_x16 = 1'b0;
	logic rxd = 1'b1;
	logic cts_n = 1'b0;
	logic dcd_n = 1'b0;
	// Design outputs
	wire [15:0] pio_rdata;
	wire rtc_en;
	wire irq;
	wire dma_req;
	wire dma_we;
	wire [15:0] dma_addr;
	wire [15:0] dma_wdata;
	wire dma_ack;
	wire [15:0] dma_rdata;
	wire txd;
	wire rts;
	// Bench state
	int fail_count = 0;
	int n_checks = 0;
	int i;
	logic [3:0] tdiv = 4'h0;
	logic [9:0] seen;

	always #25 mclk = ~mclk;
	// One bit is 16 ticks, so 64 cycles
	always @(posedge mclk)
	begin
		tdiv <= #1 tdiv + 4'h1;
		tick_x16 <= #1 (tdiv[1:0] == 2'b11);
	end

	amp_port amp_port_i (.mclk, .nrst, .pio_cmd_wr, .pio_dat_wr, .pio_stat_rd, .pio_dat_rd, .pio_wdata,
		.pio_rdata, .rtc_en, .auto_en, .cb_base, .pend_clr, .irq, .dma_req, .dma_we, .dma_addr,
		.dma_wdata, .dma_ack, .dma_rdata, .tick_x16, .rxd, .cts_n, .dcd_n, .txd, .rts);
	amp_host_mem amp_host_mem_i (.mclk, .dma_req, .dma_we, .dma_addr, .dma_wdata, .dma_ack, .dma_rdata);

	// ==========
	// Tasks
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task end_sim;
		if (fail_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// One access: op 0 command, 1 tx data, 2 status, 3 rx data
	task pio(input int op, input logic [15:0] wd);
		cyc(1);
		pio_wdata = wd;
		pio_cmd_wr = (op == 0);
		pio_dat_wr = (op == 1);
		pio_stat_rd = (op == 2);
		pio_dat_rd = (op == 3);
		cyc(1);
		{pio_cmd_wr, pio_dat_wr, pio_stat_rd, pio_dat_rd} = 4'h0;
		// Slack lets the FIFO refill the holding register
		cyc(4);
	endtask
	task rd(input int op, input logic [15:0] exp, input string what);
		pio(op, 16'h0000);
		chk(pio_rdata, exp, what);
	endtask
	// Line bits LSB first, then idle high
	task send(input logic [10:0] f, input int n);
		for (int b = 0; b < n; b++)
		begin
			rxd = f[b];
			cyc(64);
		end
		rxd = 1'b1;
		cyc(16);
	endtask
	// Bounded wait: which 1 for irq high, 0 for txd low
	task wait_for(input int which, input int lim);
		int k;
		for (k = 0; k < lim && ((which == 1) ? irq : !txd) !== 1'b1; k++)
			cyc(1);
		if (k == lim)
		begin
			chk(16'h0000, 16'h0001, "wait timed out");
			end_sim;
		end
	endtask

	// ==========
	// Main sequence
	initial
	begin
		cyc(8);
		nrst = 1'b1;
		cyc(6);
		rd(2, 16'h0002, "idle status");
		cts_n = 1'b1;
		cyc(6);
		rd(2, 16'h0008, "cts status");
		cts_n = 1'b0;
		cyc(6);
		// Mode change to 8N1, then one byte out
		pio(0, 16'h0003);
		pio(0, 16'h0015);
		pio(1, 16'h00a5);
		wait_for(0, 200);
		cyc(32);
		for (i = 0; i < 10; i++)
		begin
			seen[i] = txd;
			cyc(64);
		end
		chk({6'h00, seen}, {6'h00, 1'b1, 8'ha5, 1'b0}, "tx frame");
		rd(2, 16'h0002, "tx done");
		send({2'b11, 8'h5a, 1'b0}, 10);
		rd(2, 16'h0003, "rx full");
		rd(3, 16'h005a, "rx data");
		rd(2, 16'h0002, "rx cleared");
		// 7 bits odd parity: wrong parity, then a zero stop bit
		pio(0, 16'h0003);
		pio(0, 16'h000d);
		send({1'b1, 1'b1, 1'b0, 7'h41, 1'b0}, 10);
		rd(2, 16'h0043, "parity flag");
		rd(3, 16'h0041, "parity char");
		send({1'b1, 1'b0, 1'b1, 7'h41, 1'b0}, 10);
		rd(2, 16'h0013, "framing flag");
		rd(3, 16'h0041, "framing char");
		pio(0, 16'h0003);
		pio(0, 16'h8055);
		chk({14'h0000, rts, rtc_en}, 16'h0003, "rts and clock enable");
		// Holding register plus full FIFO keep 33 of 35, two are lost
		for (i = 0; i < 35; i++)
			send({2'b11, 8'h30 + i[7:0], 1'b0}, 10);
		rd(3, 16'h0030, "first char");
		rd(2, 16'h0023, "overrun shown");
		rd(3, 16'h0031, "second char");
		rd(2, 16'h0003, "overrun cleared");
		for (i = 2; i < 33; i++)
			rd(3, 16'h0030 + i[15:0], "fifo drain");
		rd(2, 16'h0002, "drained");
		dcd_n = 1'b1;
		cyc(6);
		rd(2, 16'h0006, "carrier lost");
		dcd_n = 1'b0;
		cyc(6);
		rd(2, 16'h0006, "carrier sticky");
		pio(3, 16'h0000);
		rd(2, 16'h0002, "carrier cleared");
		// Auto mode, single character, prompt memory
		pio(0, 16'h0003);
		pio(0, 16'h0015);
		amp_host_mem_i.mem[16'h0100] = 16'h0000;
		cb_base = 16'h0100;
		auto_en = 1'b1;
		send({2'b11, 8'h41, 1'b0}, 10);
		wait_for(1, 400);
		chk(amp_host_mem_i.mem[16'h0100], 16'h8041, "single icw");
		pend_clr = 1'b1;
		cyc(1);
		pend_clr = 1'b0;
		cyc(2);
		chk({15'h0000, irq}, 16'h0000, "pending cleared");
		// Auto buffer, specials enabled, slow memory
		amp_host_mem_i.dly = 3;
		amp_host_mem_i.mem[16'h0100] = 16'h5000;
		amp_host_mem_i.mem[16'h0104] = 16'h03ff;
		amp_host_mem_i.mem[16'h0106] = 16'h0403;
		send({2'b11, 8'h7b, 1'b0}, 10);
		cyc(100);
		chk({amp_host_mem_i.mem[16'h0200][15:8], 8'h00}, 16'hfb00, "buffer byte");
		chk(amp_host_mem_i.mem[16'h0104], 16'h0400, "byte pointer");
		send({2'b11, 8'h7c, 1'b0}, 10);
		wait_for(1, 400);
		chk(amp_host_mem_i.mem[16'h0100], 16'hd07c, "special icw");
		// A second special before the service clears completion overwrites the low byte
		send({2'b11, 8'h7d, 1'b0}, 10);
		cyc(100);
		chk(amp_host_mem_i.mem[16'h0100], 16'hd07d, "overwrite icw");
		end_sim;
	end
	// Hang guard
	initial
	begin
		repeat (100000) @(posedge mclk);
		chk(16'h0000, 16'h0001, "run timed out");
		end_sim;
	end
endmodule
